// [scp_regs.vh]
// Register indices, field positions, reset values and timing constants
`ifndef SCP_REGS_VH
`define SCP_REGS_VH
`define SCP_IDX_CTRL     12'h100
`define SCP_IDX_ENABLE   12'h101
`define SCP_IDX_FBDIV    12'h102
`define SCP_IDX_PERIOD   12'h103
`define SCP_IDX_STAB     12'h106
`define SCP_IDX_MASK     12'h209
`define SCP_IDX_CALSYNC  12'hA02
`define SCP_IDX_STATUS   12'hD01
`define SCP_IDX_MONITOR  12'hD02
`define SCP_IDX_CLEAR    12'hD03
`define SCP_CTRL_EXTLF   7
`define SCP_CTRL_CPMODE  6
`define SCP_CTRL_CPHI    5
`define SCP_CTRL_CPLO    3
`define SCP_CTRL_LDDIS   2
`define SCP_CTRL_LDHI    1
`define SCP_CTRL_LDLO    0
`define SCP_CTRL_RST     8'h18
`define SCP_FBDIV_RST    8'h28
`define SCP_PERIOD_RST   21'h00_0000
`define SCP_STAB_RST     20'h0_0000
`define SCP_ST_LOCK      0
`define SCP_ST_CAL       1
`define SCP_ST_STABLE    4
`define SCP_LOCK_BASE    11'h080
`define SCP_MS_IN_FS     40'hE8_D4A5_1000
`define SCP_CP_250UA     3'h1
`define SCP_CP_500UA     3'h3
`define SCP_CP_750UA     3'h5
`define SCP_CP_1MA       3'h7
`endif

// [scp_lock_detect.v]
// Lock detector counting consecutive in-phase phase detector samples
`timescale 1ns/10ps
`include "scp_regs.vh"
module scp_lock_detect (
  // Clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // Control
  input  wire       detEnable,
  input  wire       restart,
  input  wire [1:0] lockDiv,
  // Phase detector samples
  input  wire       sampleValid,
  input  wire       inPhase,
  // Result
  output wire       locked
);
  reg  [10:0] runCount_r;
  wire [10:0] needed = `SCP_LOCK_BASE << lockDiv;
  assign locked = detEnable & (runCount_r >= needed);
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      runCount_r <= 11'h000;
    end else if (restart | ~detEnable) begin
      runCount_r <= 11'h000;
    end else if (sampleValid) begin
      if (~inPhase) begin
        runCount_r <= 11'h000;
      end else if (runCount_r < needed) begin
        runCount_r <= runCount_r + 11'h001;
      end
    end
  end
endmodule

// [scp_stab_timer.v]
// Millisecond stability timer with a tick scaled from the clock period
`timescale 1ns/10ps
`include "scp_regs.vh"
module scp_stab_timer (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Settings
  input  wire [20:0] periodFs,
  input  wire [19:0] duration,
  // Start control
  input  wire        arm,
  input  wire        restart,
  // Result
  output wire        timedOut
);
  reg  [39:0] fsAcc_r;
  reg  [19:0] msCount_r;
  reg         done_r;
  wire [39:0] fsSum = fsAcc_r + {19'h0_0000, periodFs};
  wire        msTick = (fsSum >= `SCP_MS_IN_FS);
  assign timedOut = (duration == 20'h0_0000) | done_r;
  // A period of zero never ticks, so software must load it first
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fsAcc_r   <= 40'h00_0000_0000;
      msCount_r <= 20'h0_0000;
      done_r    <= 1'b0;
    end else if (restart | ~arm) begin
      fsAcc_r   <= 40'h00_0000_0000;
      msCount_r <= 20'h0_0000;
      done_r    <= 1'b0;
    end else if (~done_r) begin
      fsAcc_r <= msTick ? (fsSum - `SCP_MS_IN_FS) : fsSum;
      if (msTick) begin
        msCount_r <= msCount_r + 20'h0_0001;
      end
      if (msCount_r >= duration) begin
        done_r <= 1'b1;
      end
    end
  end
endmodule

// [scp_pll_ctrl.v]
// System clock multiplier PLL control with Wishbone register slave
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
`include "scp_regs.vh"
module scp_pll_ctrl (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [13:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Phase detector and input clock sense
  input  wire        pfdSampleValid,
  input  wire        pfdInPhase,
  input  wire        inputClockPresent,
  // Tank oscillator calibration handshake
  input  wire        tankAmpCalDone,
  input  wire        tankFreqCalDone,
  output reg         tankAmpCalEn,
  output reg         tankFreqCalEn,
  // Analog settings
  output reg  [2:0]  chargePumpCode,
  output reg         extLoopFilterEn,
  output reg         pllEnableOut,
  output reg  [7:0]  feedbackDivOut,
  output reg  [20:0] nominalPeriodOut,
  // Status outputs
  output reg         refMonitorEnable,
  output reg         stableToPin,
  output reg         irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_AMP  = 2'd1;
  localparam ST_FREQ = 2'd2;

  reg  [7:0]  ctrl_r;
  reg         pllEn_r;
  reg  [7:0]  fbDiv_r;
  reg  [20:0] period_r;
  reg  [19:0] stabDur_r;
  reg  [7:0]  mask_r;
  reg         calBit_r;
  reg         calBitPrev_r;
  reg         pllEnPrev_r;
  reg  [1:0]  calState_r;
  reg  [1:0]  calState_nxt;
  reg         calDonePulse;
  reg         stablePrev_r;
  reg  [7:0]  monitor_r;
  reg  [2:0]  autoCode;

  wire [11:0] regIdx = wb_adr_i[13:2];
  wire        busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wrReq = busReq & wb_we_i;
  wire [31:0] laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        wrCtrl = wrReq & (regIdx == `SCP_IDX_CTRL);
  wire        wrEnable = wrReq & (regIdx == `SCP_IDX_ENABLE);
  wire        wrFbDiv = wrReq & (regIdx == `SCP_IDX_FBDIV);
  wire        wrPeriod = wrReq & (regIdx == `SCP_IDX_PERIOD);
  wire        wrStab = wrReq & (regIdx == `SCP_IDX_STAB);
  wire        wrMask = wrReq & (regIdx == `SCP_IDX_MASK);
  wire        wrCal = wrReq & (regIdx == `SCP_IDX_CALSYNC);
  wire        wrClear = wrReq & (regIdx == `SCP_IDX_CLEAR);
  wire [31:0] periodMerged = ({11'h000, period_r} & ~laneMask) |
                             (wb_dat_i & laneMask);
  wire [31:0] stabMerged = ({12'h000, stabDur_r} & ~laneMask) |
                           (wb_dat_i & laneMask);

  wire        calibrating = (calState_r != ST_IDLE);
  wire        calLaunch = calBitPrev_r & ~calBit_r & inputClockPresent;
  wire        pllEnChange = pllEn_r ^ pllEnPrev_r;
  wire        detEnable = ~ctrl_r[`SCP_CTRL_LDDIS];
  wire        lockIndication;
  wire        timerDone;
  // Disabled PLL arms at once; enabled PLL waits for lock
  wire        timerArm = pllEn_r ? lockIndication : 1'b1;
  wire        timerRestart = pllEnChange | calLaunch | calibrating;
  wire        stableNow = timerDone & ~calibrating;
  wire [7:0]  statusVec = {3'h0, stableNow, 2'h0, calibrating, lockIndication};
  wire [7:0]  eventVec = {3'h0, stableNow & ~stablePrev_r, 2'h0, calDonePulse, 1'b0};

  scp_lock_detect u_lock (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .detEnable   (detEnable),
    .restart     (calibrating),
    .lockDiv     (ctrl_r[`SCP_CTRL_LDHI:`SCP_CTRL_LDLO]),
    .sampleValid (pfdSampleValid),
    .inPhase     (pfdInPhase),
    .locked      (lockIndication)
  );

  // Duration is read live, so it must be settled before enable changes
  // With the detector off an enabled PLL never arms the timer; done then comes only from a zero duration
  scp_stab_timer u_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .periodFs (period_r),
    .duration (stabDur_r),
    .arm      (timerArm),
    .restart  (timerRestart),
    .timedOut (timerDone)
  );

  // Register writes honour byte lanes
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r    <= `SCP_CTRL_RST;
      pllEn_r   <= 1'b0;
      fbDiv_r   <= `SCP_FBDIV_RST;
      period_r  <= `SCP_PERIOD_RST;
      stabDur_r <= `SCP_STAB_RST;
      mask_r    <= 8'h00;
      calBit_r  <= 1'b0;
    end else begin
      if (wrCtrl & wb_sel_i[0]) begin
        ctrl_r <= wb_dat_i[7:0];
      end
      if (wrEnable & wb_sel_i[0]) begin
        pllEn_r <= wb_dat_i[0];
      end
      if (wrFbDiv & wb_sel_i[0]) begin
        fbDiv_r <= wb_dat_i[7:0];
      end
      if (wrPeriod) begin
        period_r <= periodMerged[20:0];
      end
      if (wrStab) begin
        stabDur_r <= stabMerged[19:0];
      end
      if (wrMask & wb_sel_i[0]) begin
        mask_r <= wb_dat_i[7:0];
      end
      if (wrCal & wb_sel_i[0]) begin
        calBit_r <= wb_dat_i[0];
      end
    end
  end

  // Edge history for launch, enable change and stable rise
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      calBitPrev_r <= 1'b0;
      pllEnPrev_r  <= 1'b0;
      stablePrev_r <= 1'b0;
    end else begin
      calBitPrev_r <= calBit_r;
      pllEnPrev_r  <= pllEn_r;
      stablePrev_r <= stableNow;
    end
  end

  // Calibration sequencer: amplitude first, then frequency
  always @* begin
    calState_nxt = calState_r;
    calDonePulse = 1'b0;
    case (calState_r)
      ST_IDLE: begin
        if (calLaunch) begin
          calState_nxt = ST_AMP;
        end
      end
      ST_AMP: begin
        if (tankAmpCalDone) begin
          calState_nxt = ST_FREQ;
        end
      end
      ST_FREQ: begin
        if (tankFreqCalDone) begin
          calState_nxt = ST_IDLE;
          calDonePulse = 1'b1;
        end
      end
      default: begin
        calState_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      calState_r    <= ST_IDLE;
      tankAmpCalEn  <= 1'b0;
      tankFreqCalEn <= 1'b0;
    end else begin
      calState_r    <= calState_nxt;
      tankAmpCalEn  <= (calState_nxt == ST_AMP);
      tankFreqCalEn <= (calState_nxt == ST_FREQ);
    end
  end

  // Automatic current grows with the divider to keep loop gain flat
  always @* begin
    if (fbDiv_r < 8'h10) begin
      autoCode = `SCP_CP_250UA;
    end else if (fbDiv_r < 8'h40) begin
      autoCode = `SCP_CP_500UA;
    end else if (fbDiv_r < 8'h80) begin
      autoCode = `SCP_CP_750UA;
    end else begin
      autoCode = `SCP_CP_1MA;
    end
  end

  // Analog settings and status pins, all registered
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chargePumpCode   <= `SCP_CP_500UA;
      extLoopFilterEn  <= 1'b0;
      pllEnableOut     <= 1'b0;
      feedbackDivOut   <= `SCP_FBDIV_RST;
      nominalPeriodOut <= `SCP_PERIOD_RST;
      refMonitorEnable <= 1'b0;
      stableToPin      <= 1'b0;
    end else begin
      if (ctrl_r[`SCP_CTRL_CPMODE]) begin
        chargePumpCode <= ctrl_r[`SCP_CTRL_CPHI:`SCP_CTRL_CPLO];
      end else begin
        chargePumpCode <= autoCode;
      end
      extLoopFilterEn  <= ctrl_r[`SCP_CTRL_EXTLF];
      pllEnableOut     <= pllEn_r;
      feedbackDivOut   <= fbDiv_r;
      nominalPeriodOut <= period_r;
      refMonitorEnable <= stableNow;
      stableToPin      <= stableNow;
    end
  end

  // Sticky monitor bits set only when unmasked; set beats clear
  // Next value per bit, so the monitor word keeps a single driving process
  wire [7:0]  monitor_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mon
      assign monitor_nxt[gi] = (eventVec[gi] & mask_r[gi]) |
                               (monitor_r[gi] & ~(wrClear & wb_sel_i[0] & wb_dat_i[gi]));
    end
  endgenerate

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      monitor_r <= 8'h00;
    end else begin
      monitor_r <= monitor_nxt;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(monitor_r & mask_r);
    end
  end

  // Bus answer one cycle after the strobe; unmapped reads give zero
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq;
      if (busReq & ~wb_we_i) begin
        case (regIdx)
          `SCP_IDX_CTRL: begin
            wb_dat_o <= {24'h00_0000, ctrl_r};
          end
          `SCP_IDX_ENABLE: begin
            wb_dat_o <= {31'h0000_0000, pllEn_r};
          end
          `SCP_IDX_FBDIV: begin
            wb_dat_o <= {24'h00_0000, fbDiv_r};
          end
          `SCP_IDX_PERIOD: begin
            wb_dat_o <= {11'h000, period_r};
          end
          `SCP_IDX_STAB: begin
            wb_dat_o <= {12'h000, stabDur_r};
          end
          `SCP_IDX_MASK: begin
            wb_dat_o <= {24'h00_0000, mask_r};
          end
          `SCP_IDX_CALSYNC: begin
            wb_dat_o <= {31'h0000_0000, calBit_r};
          end
          `SCP_IDX_STATUS: begin
            wb_dat_o <= {24'h00_0000, statusVec};
          end
          `SCP_IDX_MONITOR: begin
            wb_dat_o <= {24'h00_0000, monitor_r};
          end
          default: begin
            wb_dat_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end
endmodule

// [scp_xtal_model.sv]
// Input clock source and tank oscillator stand-in for the PLL control block
`timescale 1ns/10ps
module scp_xtal_model #(
  parameter DLY = 4
) (
  // Clock and reset
  input  wire clk,
  input  wire sys_rst,
  // Bench controls
  input  wire clkOn,
  input  wire phaseOk,
  // Calibration enables
  input  wire ampEn,
  input  wire freqEn,
  // Outputs to the block
  output wire present,
  output reg  sampleValid,
  output reg  inPhase,
  output reg  ampDone,
  output reg  freqDone
);
  reg [3:0] cnt_r;
  assign present = clkOn;
  // Without an input clock no samples come and the phase line wanders
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sampleValid <= 1'b0;
      inPhase     <= 1'b0;
      cnt_r       <= 4'h0;
      ampDone     <= 1'b0;
      freqDone    <= 1'b0;
    end else begin
      sampleValid <= clkOn;
      inPhase     <= clkOn ? phaseOk : ~inPhase;
      cnt_r       <= ((ampEn || freqEn) && cnt_r != DLY) ? cnt_r + 4'h1 : 4'h0;
      ampDone     <= ampEn && cnt_r == DLY;
      freqDone    <= freqEn && cnt_r == DLY;
    end
  end
endmodule

// [scp_pll_ctrl_asserts.sv]
// Port-level checks for the PLL control block
`timescale 1ns/10ps
module scp_pll_ctrl_asserts (
  // Clock and reset
  input wire        clk,
  input wire        sys_rst,
  // Wishbone
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [13:0] wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  // Calibration
  input wire        inputClockPresent,
  input wire        tankAmpCalDone,
  input wire        tankFreqCalDone,
  input wire        tankAmpCalEn,
  input wire        tankFreqCalEn,
  // Settings and status
  input wire [2:0]  chargePumpCode,
  input wire        extLoopFilterEn,
  input wire [20:0] nominalPeriodOut,
  input wire        refMonitorEnable,
  input wire        stableToPin
);
  reg  calBit_r;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr  = req && wb_we_i && wb_sel_i == 4'hF;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Last calibrate bit written, so the clearing write can be told apart
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      calBit_r <= 1'b0;
    else if (wr && wb_adr_i == 14'h2808)
      calBit_r <= wb_dat_i[0];
  end
  a_ack_follows: assert property (req |=> wb_ack_o) else $error("ack missing");
  a_ext_filter: assert property (wr && wb_adr_i == 14'h0400 |-> ##2 extLoopFilterEn == $past(wb_dat_i[7], 2))
    else $error("loop filter select wrong");
  a_manual_code: assert property (wr && wb_adr_i == 14'h0400 && wb_dat_i[6]
    |-> ##2 chargePumpCode == $past(wb_dat_i[5:3], 2)) else $error("manual current wrong");
  a_period_copy: assert property (wr && wb_adr_i == 14'h040C
    |-> ##2 nominalPeriodOut == $past(wb_dat_i[20:0], 2)) else $error("period copy wrong");
  a_cal_launch: assert property (wr && wb_adr_i == 14'h2808 && !wb_dat_i[0] && calBit_r
    && inputClockPresent |-> ##[2:3] tankAmpCalEn) else $error("calibration not launched");
  a_amp_to_freq: assert property (tankAmpCalEn && tankAmpCalDone
    |=> !tankAmpCalEn && tankFreqCalEn) else $error("frequency phase not entered");
  a_freq_ends: assert property (tankFreqCalEn && tankFreqCalDone |=> !tankFreqCalEn)
    else $error("frequency phase not ended");
  a_one_phase: assert property (!(tankAmpCalEn && tankFreqCalEn)) else $error("two phases at once");
  a_pin_follows: assert property (stableToPin == refMonitorEnable) else $error("pin and monitors differ");
  a_mon_held_off: assert property ((tankAmpCalEn || tankFreqCalEn) |=> !refMonitorEnable)
    else $error("monitors enabled during calibration");
  c_amp_done: cover property (tankAmpCalEn && tankAmpCalDone);
  c_freq_done: cover property (tankFreqCalEn && tankFreqCalDone);
  c_stable: cover property ($rose(refMonitorEnable));
endmodule
bind scp_pll_ctrl scp_pll_ctrl_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .inputClockPresent(inputClockPresent), .tankAmpCalDone(tankAmpCalDone),
  .tankFreqCalDone(tankFreqCalDone), .tankAmpCalEn(tankAmpCalEn), .tankFreqCalEn(tankFreqCalEn),
  .chargePumpCode(chargePumpCode), .extLoopFilterEn(extLoopFilterEn), .nominalPeriodOut(nominalPeriodOut),
  .refMonitorEnable(refMonitorEnable), .stableToPin(stableToPin));

// [scp_pll_ctrl_tb.sv]
// Self-checking bench for the PLL control block
`timescale 1ns/10ps
module scp_pll_ctrl_tb;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         cyc = 1'b0;
  reg         we = 1'b0;
  reg  [13:0] adr = 14'h0000;
  reg  [31:0] wdat = 32'h0000_0000;
  reg         clkOn = 1'b1;
  reg         phaseOk = 1'b0;
  reg  [31:0] rv;
  wire [31:0] rdat;
  wire [20:0] perOut;
  wire [7:0]  fbOut;
  wire [2:0]  cpCode;
  wire        ack, valid, inPh, pres, aDone, fDone, aEn, fEn, extLf, pllEn, refMon, stPin, irq;
  integer     mismatches = 0;
  integer     n_tests = 0;
  integer     i;
  always #12.5 clk = ~clk;
  scp_pll_ctrl dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pfdSampleValid(valid), .pfdInPhase(inPh), .inputClockPresent(pres), .tankAmpCalDone(aDone),
    .tankFreqCalDone(fDone), .tankAmpCalEn(aEn), .tankFreqCalEn(fEn), .chargePumpCode(cpCode),
    .extLoopFilterEn(extLf), .pllEnableOut(pllEn), .feedbackDivOut(fbOut), .nominalPeriodOut(perOut),
    .refMonitorEnable(refMon), .stableToPin(stPin), .irq(irq));
  scp_xtal_model #(.DLY(4)) u_src (.clk(clk), .sys_rst(sys_rst), .clkOn(clkOn), .phaseOk(phaseOk),
    .ampEn(aEn), .freqEn(fEn), .present(pres), .sampleValid(valid), .inPhase(inPh),
    .ampDone(aDone), .freqDone(fDone));
  task end_sim;
    begin
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Request held until ack is seen at a rising edge; read data taken there
  task wb(input w, input [13:0] a, input [31:0] d);
    integer t;
    begin
      t = 0;
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && t < 20) begin
        @(posedge clk);
        t = t + 1;
      end
      if (t >= 20)
        mismatches = mismatches + 1;
      rv = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
    end
  endtask
  task rdc(input string nm, input [13:0] a, input [31:0] e);
    begin
      wb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rv);
    end
  endtask
  task wt(input [13:0] a, input [31:0] d);
    begin
      wb(1'b1, a, d);
      repeat (3) @(posedge clk);
    end
  endtask
  task cal;
    begin
      wt(14'h2808, 32'h0000_0001);
      wb(1'b1, 14'h2808, 32'h0000_0000);
      wb(1'b0, 14'h3404, 32'h0000_0000);
    end
  endtask
  initial begin
    #(25 * 20000);
    mismatches = mismatches + 1;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rdc("ctrl", 14'h0400, 32'h0000_0018);
    rdc("fbdiv", 14'h0408, 32'h0000_0028);
    rdc("status", 14'h3404, 32'h0000_0010);
    rdc("unmapped", 14'h3FFC, 32'h0000_0000);
    chk("refmon", 1, refMon);
    chk("cp code", 3, cpCode);
    $display("reset test done");
    // Auto mode must ignore a user field that differs from its own choice
    wt(14'h0408, 32'h0000_000A);
    wt(14'h0400, 32'h0000_0038);
    chk("auto low", 1, cpCode);
    wt(14'h0408, 32'h0000_00C8);
    chk("fb out", 32'h0000_00C8, fbOut);
    chk("auto high", 7, cpCode);
    for (i = 0; i < 8; i = i + 1) begin
      wt(14'h0400, 32'h0000_0040 | (i << 3));
      chk("manual", i, cpCode);
    end
    wt(14'h0400, 32'h0000_0080);
    chk("ext filter", 1, extLf);
    wt(14'h0400, 32'h0000_0018);
    chk("int filter", 0, extLf);
    wt(14'h040C, 32'h001F_FFFF);
    chk("period", 32'h001F_FFFF, perOut);
    $display("settings test done");
    wt(14'h0418, 32'h0000_0001);
    wt(14'h0404, 32'h0000_0001);
    chk("pll on", 1, pllEn);
    rdc("wait lock", 14'h3404, 32'h0000_0000);
    for (i = 0; i < 2; i = i + 1) begin
      phaseOk <= 1'b0;
      wt(14'h0400, 32'h0000_0018 | i);
      phaseOk <= 1'b1;
      repeat ((128 << i) - 24) @(posedge clk);
      rdc("no lock", 14'h3404, 32'h0000_0000);
      repeat (40) @(posedge clk);
      rdc("lock", 14'h3404, 32'h0000_0001);
    end
    chk("refmon off", 0, refMon);
    $display("lock test done");
    wt(14'h0824, 32'h0000_0010);
    wt(14'h0404, 32'h0000_0000);
    chk("pll off", 0, pllEn);
    chk("restart", 0, stPin);
    wt(14'h0418, 32'h0000_0000);
    rdc("monitor", 14'h3408, 32'h0000_0010);
    chk("irq set", 1, irq);
    wt(14'h340C, 32'h0000_0010);
    chk("irq clr", 0, irq);
    $display("interrupt test done");
    clkOn <= 1'b0;
    cal;
    chk("no clock", 0, rv[1]);
    clkOn <= 1'b1;
    cal;
    chk("cal busy", 1, rv[1]);
    chk("amp phase", 1, aEn);
    repeat (40) @(posedge clk);
    // Stable returns as calibration ends, raising the still unmasked bit 4 event
    rdc("cal unmasked", 14'h3408, 32'h0000_0010);
    wt(14'h340C, 32'h0000_0010);
    chk("stable irq clr", 0, irq);
    wt(14'h0824, 32'h0000_0002);
    cal;
    repeat (40) @(posedge clk);
    rdc("cal monitor", 14'h3408, 32'h0000_0002);
    chk("cal irq", 1, irq);
    wb(1'b0, 14'h3404, 32'h0000_0000);
    chk("stable after", 32'h0000_0010, rv & 32'h0000_0012);
    wt(14'h340C, 32'h0000_0002);
    chk("cal irq clr", 0, irq);
    $display("calibration test done");
    end_sim;
  end
endmodule
